// ==== rtl/i2c_pkg.sv ====
// shared constants and state types for the two-wire register port
`default_nettype none
package i2c_pkg;
  // 7-bit bus address the device answers to
  localparam logic [6:0] DEV_ADDR = 7'h68;
  // system clock period in ns
  localparam int CLK_PERIOD_NS = 4;
  // scl low timeout in ms, and its cycle count (longest time, rounded down)
  localparam int TIMEOUT_MS = 35;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  // cycles a synchronised line must stay changed before the filter follows
  localparam int FILTER_CYC = 3;
  // highest implemented register index and pointer value after reset
  localparam logic [7:0] LAST_REG = 8'h10;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // host: system cycles per half period of the scl it generates
  localparam int SCL_HALF_CYC = 10;
  // bit index of the acknowledge slot within a byte frame
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // last data bit index
  localparam logic [3:0] LAST_BIT = 4'h7;
  // response buffer depth
  localparam int RSP_DEPTH = 2;

  // device end: receive, ack drive, transmit, ack sample
  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_RX   = 5'h02,
    D_RACK = 5'h04,
    D_TX   = 5'h08,
    D_TACK = 5'h10
  } dev_state_t;

  // meaning of the byte being received by the device
  typedef enum logic [2:0] {
    K_ADDR = 3'h1,
    K_PTR  = 3'h2,
    K_DATA = 3'h4
  } byte_kind_t;

  // host end: bus free or held, start, bit frame, tail, stop
  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_START = 5'h02,
    M_BIT   = 5'h04,
    M_TAIL  = 5'h08,
    M_STOP  = 5'h10
  } host_state_t;
endpackage
`default_nettype wire

// ==== rtl/i2c_if.sv ====
// open-drain two-wire bus joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface i2c_if;
  // pin drivers: value and enable per party
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  // resolved wire levels, pulled high when nobody pulls low
  logic scl;
  logic sda;

  // wired-and resolution of the open-drain lines
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  // device only samples the clock
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  // host owns the clock and shares the data line
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// ==== rtl/i2c_rtc_port.sv ====
// device end of the two-wire bus: register pointer port with scl timeout
`timescale 1ns/1ps
`default_nettype none
module i2c_rtc_port #(
  parameter int TIMEOUT_CYCLES = i2c_pkg::TIMEOUT_CYC,
  parameter int FILTER_CYCLES = i2c_pkg::FILTER_CYC,
  parameter logic [7:0] LAST_REG = i2c_pkg::LAST_REG
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // two-wire bus
  i2c_if.dev bus,
  // register read side
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  // register write side
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  // transfer in progress
  output logic active_o
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int FW = $clog2(FILTER_CYCLES + 1);

  // refuse settings the counters cannot serve
  generate
    if (TIMEOUT_CYCLES < 2 || FILTER_CYCLES < 1) begin : g_bad
      $error("timeout or filter length out of range");
    end
  endgenerate

  // next pointer with wrap past the last register
  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    ptr_next = (p >= LAST_REG) ? 8'h00 : p + 8'h01;
  endfunction

  // bit 0 is scl, bit 1 is sda throughout
  logic [1:0] sync1_ff;  // first synchroniser stage
  logic [1:0] sync2_ff;  // second synchroniser stage
  logic [1:0] filt_ff;  // filtered line levels
  logic [1:0] prev_ff;  // filtered levels one cycle ago
  logic [1:0][FW-1:0] fcnt_ff;  // filter stability counters
  logic [TW-1:0] tcnt_ff;  // scl low duration
  i2c_pkg::dev_state_t st_ff;  // port state
  i2c_pkg::byte_kind_t kind_ff;  // meaning of current byte
  logic [3:0] cnt_ff;  // bit counter in byte
  logic [7:0] sh_ff;  // shift register
  logic rw_ff;  // direction of transfer
  logic [7:0] ptr_ff;  // register pointer
  logic sda_oe_ff;  // data line pull-down
  logic wr_en_ff;  // write strobe
  logic [7:0] wr_addr_ff;  // write address
  logic [7:0] wr_data_ff;  // write data

  // line events on filtered levels
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic tout;
  logic rx_done;
  logic addr_hit;
  logic ptr_load;
  logic data_wr;
  logic tx_done;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_ff <= 2'h3;
      sync2_ff <= 2'h3;
    end else begin
      sync1_ff <= {bus.sda, bus.scl};
      sync2_ff <= sync1_ff;
    end
  end

  // glitch filter follows only stable changes
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      filt_ff <= 2'h3;
      fcnt_ff <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync2_ff[i] == filt_ff[i]) begin
          fcnt_ff[i] <= '0;
        end else if (fcnt_ff[i] == FW'(FILTER_CYCLES - 1)) begin
          filt_ff[i] <= sync2_ff[i];
          fcnt_ff[i] <= '0;
        end else begin
          fcnt_ff[i] <= fcnt_ff[i] + FW'(1);
        end
      end
    end
  end

  // previous filtered levels for edge detection
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_ff <= 2'h3;
    end else begin
      prev_ff <= filt_ff;
    end
  end

  // edge and condition decode
  always_comb begin
    scl_rise = filt_ff[0] & ~prev_ff[0];
    scl_fall = ~filt_ff[0] & prev_ff[0];
    // start and stop while clock stays high
    start_det = filt_ff[0] & prev_ff[0] & prev_ff[1] & ~filt_ff[1];
    stop_det = filt_ff[0] & prev_ff[0] & ~prev_ff[1] & filt_ff[1];
    // compare once the whole byte is in
    rx_done = (st_ff == i2c_pkg::D_RX) & scl_fall & (cnt_ff == i2c_pkg::ACK_SLOT);
    addr_hit = (sh_ff[7:1] == i2c_pkg::DEV_ADDR);
    ptr_load = rx_done & (kind_ff == i2c_pkg::K_PTR);
    data_wr = rx_done & (kind_ff == i2c_pkg::K_DATA);
    tx_done = (st_ff == i2c_pkg::D_TX) & scl_fall & (cnt_ff == i2c_pkg::LAST_BIT);
    tout = (tcnt_ff == TW'(TIMEOUT_CYCLES - 1));
  end

  // scl low timer, only while a transfer is open
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tcnt_ff <= '0;
    end else if (filt_ff[0] || st_ff == i2c_pkg::D_IDLE || tout) begin
      tcnt_ff <= '0;
    end else begin
      tcnt_ff <= tcnt_ff + TW'(1);
    end
  end

  // transfer state machine
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= i2c_pkg::D_IDLE;
      kind_ff <= i2c_pkg::K_ADDR;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      rw_ff <= 1'b0;
    end else if (stop_det || tout) begin
      // stop ends the transfer; timeout waits for start
      st_ff <= i2c_pkg::D_IDLE;
    end else if (start_det) begin
      // any start, repeated too, begins with the address byte
      st_ff <= i2c_pkg::D_RX;
      kind_ff <= i2c_pkg::K_ADDR;
      cnt_ff <= 4'h0;
    end else begin
      unique case (st_ff)
        i2c_pkg::D_IDLE: begin
          // wait for a start
        end
        i2c_pkg::D_RX: begin
          if (scl_rise) begin
            sh_ff <= {sh_ff[6:0], filt_ff[1]};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (rx_done) begin
            if (kind_ff != i2c_pkg::K_ADDR || addr_hit) begin
              st_ff <= i2c_pkg::D_RACK;
              // direction bit kept for after the ack
              if (kind_ff == i2c_pkg::K_ADDR) begin
                rw_ff <= sh_ff[0];
              end
            end else begin
              st_ff <= i2c_pkg::D_IDLE;
            end
          end
        end
        i2c_pkg::D_RACK: begin
          if (scl_fall) begin
            cnt_ff <= 4'h0;
            if (kind_ff == i2c_pkg::K_ADDR && rw_ff) begin
              // read begins at the pointer as it stands
              st_ff <= i2c_pkg::D_TX;
              sh_ff <= rd_data_i;
              kind_ff <= i2c_pkg::K_DATA;
            end else begin
              // after a write address comes the pointer byte
              st_ff <= i2c_pkg::D_RX;
              kind_ff <= (kind_ff == i2c_pkg::K_ADDR) ? i2c_pkg::K_PTR : i2c_pkg::K_DATA;
            end
          end
        end
        i2c_pkg::D_TX: begin
          if (tx_done) begin
            st_ff <= i2c_pkg::D_TACK;
          end else if (scl_fall) begin
            // next lower bit onto the line
            sh_ff <= {sh_ff[6:0], 1'b0};
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        i2c_pkg::D_TACK: begin
          if (scl_rise && filt_ff[1]) begin
            // nack ends the read; line left released
            st_ff <= i2c_pkg::D_IDLE;
          end else if (scl_fall) begin
            // acknowledged: fetch next register
            st_ff <= i2c_pkg::D_TX;
            sh_ff <= rd_data_i;
            cnt_ff <= 4'h0;
          end
        end
        default: begin
          st_ff <= i2c_pkg::D_IDLE;
        end
      endcase
    end
  end

  // register pointer, kept across transfers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_ff <= i2c_pkg::PTR_RESET;
    end else if (ptr_load) begin
      ptr_ff <= sh_ff;
    end else if (data_wr || tx_done) begin
      ptr_ff <= ptr_next(ptr_ff);
    end
  end

  // write strobe toward the register file
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_en_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
    end else begin
      // store at the pointer before it advances
      wr_en_ff <= data_wr;
      if (data_wr) begin
        wr_addr_ff <= ptr_ff;
        wr_data_ff <= sh_ff;
      end
    end
  end

  // data line drive, changed only after scl has fallen
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_oe_ff <= 1'b0;
    end else begin
      // ack slot pulls low; transmit pulls for zeros
      sda_oe_ff <= (st_ff == i2c_pkg::D_RACK) | ((st_ff == i2c_pkg::D_TX) & ~sh_ff[7]);
    end
  end

  // output wiring; scl is never driven here
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe_ff;
  assign rd_addr_o = ptr_ff;
  assign wr_en_o = wr_en_ff;
  assign wr_addr_o = wr_addr_ff;
  assign wr_data_o = wr_data_ff;
  assign active_o = (st_ff != i2c_pkg::D_IDLE);
endmodule
`default_nettype wire

// ==== rtl/i2c_bus_master.sv ====
// host end of the two-wire bus: byte commands in, byte results out
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master #(
  parameter int HALF_CYCLES = i2c_pkg::SCL_HALF_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // two-wire bus
  i2c_if.host bus,
  // byte command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_start_i,
  input wire logic cmd_stop_i,
  input wire logic cmd_read_i,
  input wire logic cmd_last_i,
  input wire logic [7:0] cmd_data_i,
  // byte result
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [7:0] rsp_data_o,
  output logic rsp_nack_o
);
  localparam int HW = $clog2(HALF_CYCLES + 1);

  // half period must allow the device filter to follow
  generate
    if (HALF_CYCLES < 8) begin : g_bad
      $error("scl half period too short");
    end
  endgenerate

  // pull-down wanted for bit b of a byte frame
  function automatic logic drive(input logic [3:0] b, input logic [7:0] d, input logic rd, input logic last);
    // ack read bytes except the last
    if (b == i2c_pkg::ACK_SLOT) begin
      drive = rd & ~last;
    end else begin
      // msb of the shift register goes out
      drive = ~rd & ~d[7];
    end
  endfunction

  i2c_pkg::host_state_t st_ff;  // sequencer state
  logic [HW-1:0] hcnt_ff;  // cycles within half period
  logic [1:0] step_ff;  // half period index within a phase
  logic [3:0] bcnt_ff;  // bit index in frame
  logic [7:0] sh_ff;  // shift register
  logic rd_ff;  // current byte is read
  logic last_ff;  // nack after this read byte
  logic stp_ff;  // stop after this byte
  logic scl_oe_ff;  // scl pull-down
  logic sda_oe_ff;  // sda pull-down
  logic [1:0] sda_sync_ff;  // sda synchroniser
  logic [8:0] rsp_mem [i2c_pkg::RSP_DEPTH];  // result buffer
  logic wp_ff;  // buffer write slot
  logic rp_ff;  // buffer read slot
  logic [1:0] fill_ff;  // buffered results
  logic half_end;
  logic take;
  logic push;
  logic pop;

  // sequencing strobes
  always_comb begin
    half_end = (hcnt_ff == HW'(HALF_CYCLES - 1));
    // full buffer stalls the next byte, holding scl low unless a stop ended the last byte
    cmd_ready_o = (st_ff == i2c_pkg::M_IDLE) & (fill_ff < 2'h2);
    take = cmd_valid_i & cmd_ready_o;
    push = (st_ff == i2c_pkg::M_BIT) & half_end & step_ff[0] & (bcnt_ff == i2c_pkg::ACK_SLOT);
    pop = rsp_valid_o & rsp_ready_i;
  end

  // sda synchroniser; scl is our own
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_sync_ff <= 2'h3;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
    end
  end

  // half period timer
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hcnt_ff <= '0;
    end else if (st_ff == i2c_pkg::M_IDLE || half_end) begin
      hcnt_ff <= '0;
    end else begin
      hcnt_ff <= hcnt_ff + HW'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= i2c_pkg::M_IDLE;
      step_ff <= 2'h0;
      bcnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      rd_ff <= 1'b0;
      last_ff <= 1'b0;
      stp_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        i2c_pkg::M_IDLE: begin
          if (take) begin
            sh_ff <= cmd_data_i;
            rd_ff <= cmd_read_i;
            last_ff <= cmd_last_i;
            stp_ff <= cmd_stop_i;
            step_ff <= 2'h0;
            bcnt_ff <= 4'h0;
            if (cmd_start_i) begin
              st_ff <= i2c_pkg::M_START;
              sda_oe_ff <= 1'b0;
            end else begin
              st_ff <= i2c_pkg::M_BIT;
              scl_oe_ff <= 1'b1;
              sda_oe_ff <= drive(4'h0, cmd_data_i, cmd_read_i, cmd_last_i);
            end
          end
        end
        i2c_pkg::M_START: begin
          // also a repeated start from a held-low clock
          if (half_end) begin
            step_ff <= step_ff + 2'h1;
            if (step_ff == 2'h0) begin
              scl_oe_ff <= 1'b0;
            end else if (step_ff == 2'h1) begin
              sda_oe_ff <= 1'b1;
            end else begin
              scl_oe_ff <= 1'b1;
              sda_oe_ff <= drive(4'h0, sh_ff, rd_ff, last_ff);
              step_ff <= 2'h0;
              st_ff <= i2c_pkg::M_BIT;
            end
          end
        end
        i2c_pkg::M_BIT: begin
          if (half_end) begin
            step_ff <= {1'b0, ~step_ff[0]};
            if (!step_ff[0]) begin
              // low half over: raise scl
              scl_oe_ff <= 1'b0;
            end else begin
              // high half over: sample and lower scl
              scl_oe_ff <= 1'b1;
              if (bcnt_ff == i2c_pkg::ACK_SLOT) begin
                st_ff <= i2c_pkg::M_TAIL;
              end else begin
                sh_ff <= {sh_ff[6:0], sda_sync_ff[1]};
                bcnt_ff <= bcnt_ff + 4'h1;
                sda_oe_ff <= drive(bcnt_ff + 4'h1, {sh_ff[6:0], sda_sync_ff[1]}, rd_ff, last_ff);
              end
            end
          end
        end
        i2c_pkg::M_TAIL: begin
          // release sda a half period after scl fell
          if (half_end) begin
            sda_oe_ff <= 1'b0;
            step_ff <= 2'h0;
            // stop after the last byte when asked
            st_ff <= stp_ff ? i2c_pkg::M_STOP : i2c_pkg::M_IDLE;
          end
        end
        i2c_pkg::M_STOP: begin
          if (half_end) begin
            step_ff <= step_ff + 2'h1;
            if (step_ff == 2'h0) begin
              sda_oe_ff <= 1'b1;
            end else if (step_ff == 2'h1) begin
              scl_oe_ff <= 1'b0;
            end else begin
              sda_oe_ff <= 1'b0;
              step_ff <= 2'h0;
              st_ff <= i2c_pkg::M_IDLE;
            end
          end
        end
        default: begin
          st_ff <= i2c_pkg::M_IDLE;
        end
      endcase
    end
  end

  // two-entry result buffer
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      fill_ff <= 2'h0;
      rsp_mem[0] <= 9'h000;
      rsp_mem[1] <= 9'h000;
    end else begin
      if (push) begin
        rsp_mem[wp_ff] <= {sda_sync_ff[1], sh_ff};
        wp_ff <= ~wp_ff;
      end
      if (pop) begin
        rp_ff <= ~rp_ff;
      end
      fill_ff <= fill_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // pin and result outputs
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_ff;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe_ff;
  assign rsp_valid_o = (fill_ff != 2'h0);
  assign rsp_data_o = rsp_mem[rp_ff][7:0];
  assign rsp_nack_o = rsp_mem[rp_ff][8];
endmodule
`default_nettype wire

// ==== tb/i2c_link_props.sv ====
// checker for device-side behaviour on the shared two-wire bus
`timescale 1ns/1ps
`default_nettype none
module i2c_link_props #(
  parameter int TIMEOUT_CYCLES = 400
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // resolved lines and device enable
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe
);
  logic scl_ff;  // line levels one cycle back
  logic sda_ff;
  logic wsel_ff;  // write transfer addressed to us
  logic rsel_ff;  // read transfer addressed to us
  logic [9:0] cnt_ff;  // clock rises since start
  logic [7:0] sr_ff;  // bits taken at rises
  int low_ff;  // cycles with scl low
  wire start_ev = scl & scl_ff & sda_ff & ~sda;
  wire stop_ev = scl & scl_ff & ~sda_ff & sda;
  wire rise_ev = scl & ~scl_ff;
  wire ack_rise = rise_ev & ((cnt_ff % 10'h9) == 10'h8);
  wire hit = sr_ff[7:1] == i2c_pkg::DEV_ADDR;

  // delayed line levels for edge finding
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
    end
  end

  // bit counter, cleared by start, and shifter
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= 10'h0;
      sr_ff <= 8'h0;
    end else if (start_ev) begin
      cnt_ff <= 10'h0;
    end else if (rise_ev) begin
      cnt_ff <= cnt_ff + 10'h1;
      sr_ff <= {sr_ff[6:0], sda};
    end
  end

  // direction of an addressed transfer
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wsel_ff <= 1'b0;
      rsel_ff <= 1'b0;
    end else if (start_ev) begin
      wsel_ff <= 1'b0;
      rsel_ff <= 1'b0;
    end else if (rise_ev && cnt_ff == 10'h8) begin
      wsel_ff <= hit & ~sr_ff[0];
      rsel_ff <= hit & sr_ff[0];
    end
  end

  // length of the current scl low phase
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_ff <= 0;
    end else if (scl) begin
      low_ff <= 0;
    end else begin
      low_ff <= low_ff + 1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  chk_addr_ack_match: assert property (rise_ev && cnt_ff == 10'h8 |-> sda == !hit)
    else $error("address acknowledge wrong");
  chk_write_ack: assert property (ack_rise && wsel_ff |-> !sda)
    else $error("received byte not acknowledged");
  chk_nack_release: assert property (ack_rise && rsel_ff && sda |=> !dev_sda_oe [*8])
    else $error("data driven after not-acknowledge");
  chk_addr_quiet: assert property (rise_ev && cnt_ff < 10'h8 |-> !dev_sda_oe)
    else $error("data driven during address byte");
  chk_stop_quiet: assert property (stop_ev |=> !dev_sda_oe [*8])
    else $error("data driven after stop");
  chk_high_stable: assert property (scl && scl_ff |-> $stable(dev_sda_oe))
    else $error("data enable moved while clock high");
  chk_filter_lag: assert property ($fell(scl) |-> $stable(dev_sda_oe) [*6])
    else $error("data enable moved too soon after clock fall");
  chk_timeout_free: assert property (low_ff == TIMEOUT_CYCLES + 12 |-> !dev_sda_oe)
    else $error("data still driven after clock timeout");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// bench: host end drives the device end across the shared bus
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TMO = 400;  // shortened scl-low timeout
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic [3:0] cf = 4'h0;  // start, stop, read, last
  logic [7:0] c_data = 8'h0;
  logic rsp_valid;
  logic rsp_rdy = 1'b0;  // result pop, raised by the bench after checking
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic active;
  logic [7:0] regs [0:16];  // register file behind the port
  int n_mismatch = 0;
  int samples_checked = 0;

  // system clock, 4 ns
  always #2 clock_i = ~clock_i;

  i2c_if i2c_if_inst ();
  i2c_rtc_port #(.TIMEOUT_CYCLES(TMO)) i2c_rtc_port_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .bus(i2c_if_inst.dev), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .active_o(active));
  i2c_bus_master i2c_bus_master_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .bus(i2c_if_inst.host),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_start_i(cf[3]), .cmd_stop_i(cf[2]),
    .cmd_read_i(cf[1]), .cmd_last_i(cf[0]), .cmd_data_i(c_data), .rsp_valid_o(rsp_valid),
    .rsp_ready_i(rsp_rdy), .rsp_data_o(rsp_data), .rsp_nack_o(rsp_nack));
  i2c_link_props #(.TIMEOUT_CYCLES(TMO)) i2c_link_props_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .scl(i2c_if_inst.scl), .sda(i2c_if_inst.sda), .dev_sda_oe(i2c_if_inst.dev_sda_oe));

  // read side of the register file
  assign rd_data = (rd_addr <= 8'h10) ? regs[rd_addr] : 8'hee;

  // store side of the register file
  always @(posedge clock_i) begin
    if (wr_en === 1'b1) begin
      regs[wr_addr] <= wr_data;
    end
  end

  // compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one byte command, wait for its result, check it while held, then pop it
  task automatic op(input logic [3:0] f, input logic [7:0] d, input logic en, input logic [7:0] ed);
    int k;
    k = 0;
    @(negedge clock_i);
    while (cmd_ready !== 1'b1 && k < 1500) begin
      @(negedge clock_i);
      k++;
    end
    cmd_valid = 1'b1;
    cf = f;
    c_data = d;
    @(negedge clock_i);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && k < 1500) begin
      @(negedge clock_i);
      k++;
    end
    // a wait that runs out is a failure and ends the run
    if (k >= 1500) begin
      chk("wait", 8'h01, 8'h00);
      stop_test();
    end
    // result must stay in the buffer while the pop is held off
    @(negedge clock_i);
    chk("ack", {7'h0, rsp_nack}, {7'h0, en});
    if (f[1]) chk("data", rsp_data, ed);
    rsp_rdy = 1'b1;
    @(negedge clock_i);
    rsp_rdy = 1'b0;
  endtask

  // closing counts and verdict
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog against a hung bus
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end

  // test sequence
  initial begin
    for (int i = 0; i < 17; i++) regs[i] = 8'h40 + 8'(i);
    repeat (2) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (8) @(negedge clock_i);
    // write two bytes from 0x0f, pointer wraps
    op(4'h8, 8'hd0, 1'b0, 8'h0);
    op(4'h0, 8'h0f, 1'b0, 8'h0);
    op(4'h0, 8'ha5, 1'b0, 8'h0);
    op(4'h4, 8'h3c, 1'b0, 8'h0);
    chk("reg0f", regs[15], 8'ha5);
    chk("reg10", regs[16], 8'h3c);
    chk("ptr", rd_addr, 8'h00);
    $display("test write finished");
    // read from the current pointer
    op(4'h8, 8'hd1, 1'b0, 8'h0);
    op(4'h2, 8'h00, 1'b0, 8'h40);
    op(4'h7, 8'h00, 1'b1, 8'h41);
    chk("ptr", rd_addr, 8'h02);
    $display("test current read finished");
    // set pointer then repeated start read across the wrap
    op(4'h8, 8'hd0, 1'b0, 8'h0);
    op(4'h0, 8'h10, 1'b0, 8'h0);
    op(4'h8, 8'hd1, 1'b0, 8'h0);
    op(4'h2, 8'h00, 1'b0, 8'h3c);
    op(4'h7, 8'h00, 1'b1, 8'h40);
    $display("test pointer read finished");
    // foreign addresses get no answer
    op(4'hc, 8'ha0, 1'b1, 8'h0);
    op(4'hc, 8'hd2, 1'b1, 8'h0);
    op(4'hc, 8'h50, 1'b1, 8'h0);
    chk("ptr", rd_addr, 8'h01);
    $display("test foreign finished");
    // clock held low past the timeout
    op(4'h8, 8'hd1, 1'b0, 8'h0);
    chk("active", {7'h0, active}, 8'h01);
    repeat (TMO + 40) @(negedge clock_i);
    chk("active", {7'h0, active}, 8'h00);
    op(4'h4, 8'h07, 1'b1, 8'h0);
    op(4'hc, 8'hd0, 1'b0, 8'h0);
    $display("test timeout finished");
    stop_test();
  end
endmodule
`default_nettype wire
